// File: rtl/cpmc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts for power-mode control.
// Assumes: 10 MHz reference clock.
// Notes: Definitions only.
`ifndef CPMC_DEFS_SVH
`define CPMC_DEFS_SVH
`define CPMC_PWR_CTRL_OFS 8'h87
`define CPMC_BIT_IDLE 0
`define CPMC_BIT_STOP 1
`define CPMC_BIT_S1STAT 3
`define CPMC_BIT_S1BAUD 4
`define CPMC_BIT_S0STAT 6
`define CPMC_BIT_S0BAUD 7
`define CPMC_PWR_CTRL_RST 8'h00
`define CPMC_KEEP_MASK 8'hd8
`define CPMC_RESET_VECTOR 16'h0000
`define CPMC_CLK_PERIOD_NS 100
`define CPMC_MCD_TIMEOUT_US 100
`define CPMC_MCD_CYCLES ((`CPMC_MCD_TIMEOUT_US * 1000) / `CPMC_CLK_PERIOD_NS)
`define CPMC_RST_SEQ_CYCLES 12
`endif

// File: rtl/cpmc_pkg.sv
// Purpose: Types for power-mode control.
// Assumes: Constants live in cpmc_defs.svh.
// Notes: Mode state is one-hot.
package cpmc_pkg;
   typedef enum logic [3:0] {
      CPMC_RESET = 4'h1,
      CPMC_RUN = 4'h2,
      CPMC_IDLE = 4'h4,
      CPMC_STOP = 4'h8
   } cpmc_mode_e;
endpackage : cpmc_pkg

// File: rtl/cpmc_strobe_bit.sv
// Purpose: One write-one strobe bit that always reads as zero.
// Assumes: Write strobe is one cycle long.
// Notes: Registered so the request stands after the writing cycle completes.
`timescale 1ns/1ps
module cpmc_strobe_bit (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Request
   input wire logic setPulse,
   output logic strobe
);
   logic strobe_r;
   logic strobe_nxt;

   always_comb begin
      strobe_nxt = setPulse;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         strobe_r <= 1'b0;
      end else begin
         strobe_r <= strobe_nxt;
      end
   end

   assign strobe = strobe_r;
endmodule : cpmc_strobe_bit

// File: rtl/cpmc_reset_stretch.sv
// Purpose: Stretches any reset request into a fixed reset sequence.
// Assumes: Request is synchronous to ref_clk.
// Notes: Sequence restarts while the request stays high.
`timescale 1ns/1ps
`include "cpmc_defs.svh"
module cpmc_reset_stretch (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Request and result
   input wire logic rstReq,
   output logic inReset
);
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;

   always_comb begin
      if (rstReq) begin
         cnt_nxt = 5'(`CPMC_RST_SEQ_CYCLES);
      end else if (cnt_r != 5'h00) begin
         cnt_nxt = cnt_r - 5'h01;
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 5'(`CPMC_RST_SEQ_CYCLES);
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign inReset = (cnt_r != 5'h00);
endmodule : cpmc_reset_stretch

// File: rtl/cpmc_power_mode_ctrl.sv
// Purpose: Power-mode control: run, idle and stop with the power control register.
// Assumes: Register port strobes are one cycle; instrDone marks the end of an instruction.
// Notes: The missing-clock detector is modelled as a counter of cycles spent in stop mode while the detector is enabled.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "cpmc_defs.svh"
module cpmc_power_mode_ctrl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Core side
   input wire logic instrDone,
   input wire logic irqPending,
   input wire logic extResetReq,
   input wire logic missing_clock_detector,
   output logic coreRun,
   output logic coreClkEn,
   output logic periphClkEn,
   output logic oscEn,
   output logic coreReset,
   output logic [15:0] fetchAddr,
   output logic fetchLoad,
   // Serial configuration bits
   output logic serial0_baud_double,
   output logic serial0_status_access,
   output logic serial1_baud_double,
   output logic serial1_status_access
);
   cpmc_pkg::cpmc_mode_e mode_r;
   cpmc_pkg::cpmc_mode_e mode_nxt;
   logic [7:0] power_control_reg_r;
   logic [7:0] power_control_reg_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [10:0] mcdCnt_r;
   logic [10:0] mcdCnt_nxt;
   logic mcdReset;
   logic pwrWr;
   logic stopReq;
   logic idleReq;
   logic stopPend_r;
   logic stopPend_nxt;
   logic idlePend_r;
   logic idlePend_nxt;
   logic inReset;
   logic fetchLoad_r;
   logic fetchLoad_nxt;

   assign pwrWr = regWr && (regAddr == `CPMC_PWR_CTRL_OFS);

   // The strobe bits store nothing readable; they only raise a request.
   cpmc_strobe_bit u_stop_bit (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .setPulse(pwrWr && regWdata[`CPMC_BIT_STOP]),
      .strobe(stopReq)
   );

   cpmc_strobe_bit u_idle_bit (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .setPulse(pwrWr && regWdata[`CPMC_BIT_IDLE]),
      .strobe(idleReq)
   );

   // The detector times how long the device has been in stop mode with the oscillator off.
   always_comb begin
      if (missing_clock_detector && (mode_r == cpmc_pkg::CPMC_STOP)) begin
         mcdCnt_nxt = (mcdCnt_r == 11'(`CPMC_MCD_CYCLES)) ? mcdCnt_r : mcdCnt_r + 11'h001;
      end else begin
         mcdCnt_nxt = 11'h000;
      end
   end

   assign mcdReset = (mcdCnt_r == 11'(`CPMC_MCD_CYCLES));

   cpmc_reset_stretch u_rst (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .rstReq(extResetReq || mcdReset),
      .inReset(inReset)
   );

   always_comb begin
      power_control_reg_nxt = power_control_reg_r;
      if (pwrWr) begin
         power_control_reg_nxt = regWdata & `CPMC_KEEP_MASK;
      end
      rdata_nxt = 8'h00;
      if (regRd && (regAddr == `CPMC_PWR_CTRL_OFS)) begin
         rdata_nxt = power_control_reg_r;
      end
   end

   // Requests wait here until the writing instruction retires.
   always_comb begin
      stopPend_nxt = stopPend_r || stopReq;
      idlePend_nxt = idlePend_r || idleReq;
      mode_nxt = mode_r;
      fetchLoad_nxt = 1'b0;
      case (mode_r)
         cpmc_pkg::CPMC_RESET: begin
            stopPend_nxt = 1'b0;
            idlePend_nxt = 1'b0;
            if (!inReset) begin
               mode_nxt = cpmc_pkg::CPMC_RUN;
               fetchLoad_nxt = 1'b1;
            end
         end
         cpmc_pkg::CPMC_RUN: begin
            if (instrDone && stopPend_nxt) begin
               mode_nxt = cpmc_pkg::CPMC_STOP;
               stopPend_nxt = 1'b0;
               idlePend_nxt = 1'b0;
            end else if (instrDone && idlePend_nxt) begin
               mode_nxt = cpmc_pkg::CPMC_IDLE;
               idlePend_nxt = 1'b0;
            end
         end
         cpmc_pkg::CPMC_IDLE: begin
            if (irqPending) begin
               mode_nxt = cpmc_pkg::CPMC_RUN;
            end
         end
         cpmc_pkg::CPMC_STOP: begin
            mode_nxt = cpmc_pkg::CPMC_STOP;
         end
         default: begin
            mode_nxt = cpmc_pkg::CPMC_RESET;
         end
      endcase
      if (inReset) begin
         mode_nxt = cpmc_pkg::CPMC_RESET;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_r <= cpmc_pkg::CPMC_RESET;
         power_control_reg_r <= `CPMC_PWR_CTRL_RST;
         rdata_r <= 8'h00;
         mcdCnt_r <= 11'h000;
         stopPend_r <= 1'b0;
         idlePend_r <= 1'b0;
         fetchLoad_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         power_control_reg_r <= power_control_reg_nxt;
         rdata_r <= rdata_nxt;
         mcdCnt_r <= mcdCnt_nxt;
         stopPend_r <= stopPend_nxt;
         idlePend_r <= idlePend_nxt;
         fetchLoad_r <= fetchLoad_nxt;
      end
   end

   assign regRdata = rdata_r;
   assign coreRun = (mode_r == cpmc_pkg::CPMC_RUN);
   assign coreClkEn = (mode_r == cpmc_pkg::CPMC_RUN);
   // Analog blocks are not touched here, so software must power them down first.
   assign periphClkEn = (mode_r != cpmc_pkg::CPMC_STOP);
   assign oscEn = (mode_r != cpmc_pkg::CPMC_STOP);
   assign coreReset = (mode_r == cpmc_pkg::CPMC_RESET);
   assign fetchLoad = fetchLoad_r;
   assign fetchAddr = `CPMC_RESET_VECTOR;
   assign serial0_baud_double = power_control_reg_r[`CPMC_BIT_S0BAUD];
   assign serial0_status_access = power_control_reg_r[`CPMC_BIT_S0STAT];
   assign serial1_baud_double = power_control_reg_r[`CPMC_BIT_S1BAUD];
   assign serial1_status_access = power_control_reg_r[`CPMC_BIT_S1STAT];

   stop_entry_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (mode_r == cpmc_pkg::CPMC_RUN && instrDone && stopPend_nxt && !inReset)
      |=> mode_r == cpmc_pkg::CPMC_STOP) else $error("stop not entered");

   stop_clocks_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (mode_r == cpmc_pkg::CPMC_STOP) |-> (!oscEn && !periphClkEn && !coreClkEn))
      else $error("clocks run in stop");

   stop_noirq_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (mode_r == cpmc_pkg::CPMC_STOP && irqPending && !inReset)
      |=> mode_r == cpmc_pkg::CPMC_STOP) else $error("irq woke stop");

   sequence rstSeqDone_s;
      coreReset ##1 !coreReset;
   endsequence
   reset_vector_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      rstSeqDone_s |-> (fetchLoad && fetchAddr == 16'h0000 && coreRun))
      else $error("no fetch at zero");

   // The timeout loads the reset stretcher first, so the mode follows two edges later.
   mcd_reset_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (mode_r == cpmc_pkg::CPMC_STOP && missing_clock_detector && mcdReset)
      |-> ##2 coreReset) else $error("detector did not reset");

   idle_entry_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (mode_r == cpmc_pkg::CPMC_IDLE) |-> (!coreClkEn && periphClkEn && oscEn))
      else $error("idle clocks wrong");

   idle_wake_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (mode_r == cpmc_pkg::CPMC_IDLE && irqPending && !inReset)
      |=> coreRun && !idlePend_r) else $error("idle not ended");

   strobe_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      $past(regRd) |-> (regRdata[`CPMC_BIT_STOP] == 1'b0 && regRdata[`CPMC_BIT_IDLE] == 1'b0))
      else $error("strobe bit read nonzero");
endmodule : cpmc_power_mode_ctrl

// File: verification/core_power_mode_control_tb.sv
// Purpose: Self-checking bench for power-mode control: reset, register, idle, stop and detector wake.
// Assumes: Register read data stand only in the cycle after the read strobe.
// Notes: The bench drives all ports itself; mode changes are awaited under bounded counts.
`timescale 1ns/1ps
`include "cpmc_defs.svh"
module core_power_mode_control_tb;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdata;
   logic instrDone = 1'b0;
   logic irqPending = 1'b0;
   logic extResetReq = 1'b0;
   logic mcdEn = 1'b0;
   logic coreRun, coreClkEn, periphClkEn, oscEn, coreReset, fetchLoad;
   logic [15:0] fetchAddr;
   logic s0Baud, s0Stat, s1Baud, s1Stat;
   int bad_count = 0;
   int n_checks = 0;
   logic [7:0] rdVal;

   cpmc_power_mode_ctrl u_dut (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .instrDone(instrDone), .irqPending(irqPending),
      .extResetReq(extResetReq), .missing_clock_detector(mcdEn), .coreRun(coreRun), .coreClkEn(coreClkEn),
      .periphClkEn(periphClkEn), .oscEn(oscEn), .coreReset(coreReset), .fetchAddr(fetchAddr),
      .fetchLoad(fetchLoad), .serial0_baud_double(s0Baud), .serial0_status_access(s0Stat),
      .serial1_baud_double(s1Baud), .serial1_status_access(s1Stat));

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 rdVal = regRdata;
   endtask : rd

   // Retire one instruction; the pending mode request takes effect here.
   task automatic retire();
      @(posedge ref_clk);
      instrDone <= 1'b1;
      @(posedge ref_clk);
      instrDone <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : retire

   // Waits for the reset vector load and checks the sequence was not cut short.
   task automatic await_fetch();
      int n;
      n = 0;
      while (fetchLoad !== 1'b1 && n < 60) begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk(fetchLoad, 1'b1, "reset vector load");
      chk(n >= `CPMC_RST_SEQ_CYCLES, 1'b1, "reset sequence length");
      chk(fetchAddr, `CPMC_RESET_VECTOR, "fetch address");
      @(posedge ref_clk);
      #1 chk(coreRun, 1'b1, "running after reset");
   endtask : await_fetch

   task automatic test_regs();
      rd(`CPMC_PWR_CTRL_OFS);
      chk(rdVal, `CPMC_PWR_CTRL_RST, "reset value");
      wr(`CPMC_PWR_CTRL_OFS, 8'hd8);
      rd(`CPMC_PWR_CTRL_OFS);
      chk(rdVal, 8'hd8, "storage bits");
      chk({s0Baud, s0Stat, s1Baud, s1Stat}, 4'hf, "serial bits out");
      rd(8'h86);
      chk(rdVal, 8'h00, "unmapped read");
      wr(8'h86, 8'h02);
      retire();
      chk(coreRun, 1'b1, "unmapped write ignored");
      wr(`CPMC_PWR_CTRL_OFS, 8'h00);
      chk({s0Baud, s0Stat, s1Baud, s1Stat}, 4'h0, "serial bits clear");
   endtask : test_regs

   task automatic test_idle();
      wr(`CPMC_PWR_CTRL_OFS, 8'h01);
      rd(`CPMC_PWR_CTRL_OFS);
      chk(rdVal, 8'h00, "idle bit reads zero");
      chk(coreRun, 1'b1, "runs until instruction retires");
      retire();
      chk({coreRun, coreClkEn, periphClkEn, oscEn}, 4'h3, "idle outputs");
      @(posedge ref_clk);
      irqPending <= 1'b1;
      @(posedge ref_clk);
      irqPending <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk({coreRun, coreClkEn, coreReset}, 3'h6, "idle wake by interrupt");
      retire();
      chk(coreRun, 1'b1, "idle request cleared");
   endtask : test_idle

   task automatic test_stop();
      wr(`CPMC_PWR_CTRL_OFS, 8'h03);
      rd(`CPMC_PWR_CTRL_OFS);
      chk(rdVal, 8'h00, "stop bit reads zero");
      retire();
      chk({coreRun, coreClkEn, periphClkEn, oscEn}, 4'h0, "stop outputs");
      @(posedge ref_clk);
      irqPending <= 1'b1;
      repeat (4) @(posedge ref_clk);
      irqPending <= 1'b0;
      @(posedge ref_clk);
      #1 chk({coreRun, oscEn}, 2'h0, "interrupt ignored in stop");
      @(posedge ref_clk);
      extResetReq <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 chk(coreReset, 1'b1, "reset ends stop");
      extResetReq <= 1'b0;
      await_fetch();
   endtask : test_stop

   task automatic test_detector();
      int n;
      mcdEn <= 1'b1;
      wr(`CPMC_PWR_CTRL_OFS, 8'h02);
      retire();
      chk(oscEn, 1'b0, "stopped with detector on");
      n = 0;
      while (coreReset !== 1'b1 && n < 1100) begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk(coreReset, 1'b1, "detector reset");
      chk(n >= 990, 1'b1, "detector timeout length");
      mcdEn <= 1'b0;
      await_fetch();
   endtask : test_detector

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      #1 chk(coreReset, 1'b1, "in reset sequence");
      await_fetch();
      test_regs();
      test_idle();
      test_stop();
      test_detector();
      stop_test();
   end

   // The tests need about 1,100 cycles; this bound of 20000 cycles leaves ample margin.
   initial begin
      #(20000 * 100);
      bad_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end
endmodule : core_power_mode_control_tb
